// ---- hw/lvdc_filter.sv ----
// Comparator synchroniser and minimum-duration qualifier
module lvdc_filter (
    input  wire logic clock,   // System clock
    input  wire logic sys_rst, // Synchronous reset
    input  wire logic ce,      // Clock enable
    lvdc_cmp_if.filt  cmp      // Arm, raw level, qualified flag
);
    import lvdc_pkg::*;

    typedef struct packed {
        logic                 sync1;
        logic                 sync2;
        logic [PERSIST_W-1:0] count;
        logic                 below;
    } lvdc_filt_st_t;

    lvdc_filt_st_t st;
    lvdc_filt_st_t next_st;

    // Two flops first; the count only ever looks at the second one
    always_comb
    begin
        next_st       = st;
        next_st.sync1 = cmp.raw;
        next_st.sync2 = st.sync1;
        if (!cmp.arm || !st.sync2)
        begin
            // Disabled or back at level: flag drops at once
            next_st.count = '0;
            next_st.below = 1'b0;
        end
        else if (st.count == PERSIST_W'(PERSIST_CYC - 1))
        begin
            next_st.below = 1'b1;
        end
        else
        begin
            next_st.count = st.count + PERSIST_W'(1);
        end
    end

    // Short dips never reach the flag, which also filters glitches
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            st <= '0;
        else if (ce)
            st <= next_st;
    end

    assign cmp.below = st.below;

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    flag_persist_a: assert property (
        $rose(st.below) |-> $past(st.count) == PERSIST_W'(PERSIST_CYC - 1))
        else $error("flag set before the minimum below time");
    sync_path_a: assert property (
        ce && !st.sync2 |=> !st.below)
        else $error("flag set without synchronised below level");
endmodule

// ---- hw/lvdc_top.sv ----
// Low-voltage detector control: registers, mode logic and reset request
module lvdc_top (
    input  wire logic        clock,          // System clock, 20 MHz
    input  wire logic        sys_rst,        // Any non-detector reset
    input  wire logic        ce,             // Clock enable
    input  wire logic [15:0] mem_addr,       // Bus address
    input  wire logic        mem_rd,         // Read strobe
    input  wire logic        mem_wr,         // Byte write strobe
    input  wire logic        mem_bit_wr,     // Single-bit write strobe
    input  wire logic [2:0]  mem_bit_pos,    // Bit number for bit write
    input  wire logic [7:0]  mem_wdata,      // Write data, bit 0 for bit wr
    output logic      [7:0]  mem_rdata,      // Registered read data
    input  wire logic        comp_below_raw, // Async comparator, 1 = below
    output logic             comp_enable,    // Runs the comparator
    output logic             use_fixed_ref,  // Sense pin vs fixed reference
    output logic [lvdc_pkg::LVL_W-1:0] threshold_level, // Level code
    output logic             low_voltage_irq,       // Interrupt pulse
    output logic             detector_reset_req,    // Internal reset level
    output logic             reset_cause_set,       // Cause bit set pulse
    output logic             irq_mask_set,          // Mask flag set level
    output logic [lvdc_pkg::DIR_W-1:0] pin_oe       // Pin output enables
);
    import lvdc_pkg::*;

    typedef struct packed {
        logic             enable;
        logic             src;
        logic             mode;
        logic [LVL_W-1:0] lvl;
        logic [DIR_W-1:0] dir;
        logic             prev_flag;
        logic             irq;
        logic             rst_req;
        logic             cause;
        logic [7:0]       rdata;
    } lvdc_top_st_t;

    localparam lvdc_top_st_t ST_RST = '{
        enable:  CTL_RST[CTL_EN_BIT],
        src:     CTL_RST[SRC_BIT],
        mode:    CTL_RST[MODE_BIT],
        lvl:     LVL_RST[LVL_W-1:0],
        dir:     DIR_RST[DIR_W-1:0],
        default: '0
    };

    lvdc_top_st_t st;
    lvdc_top_st_t next_st;
    logic         flag;
    logic         wr_any;
    logic [7:0]   ctl_img;
    logic [7:0]   lvl_img;
    logic [7:0]   dir_img;
    logic [7:0]   w_ctl;
    logic [7:0]   w_lvl;
    logic [7:0]   w_dir;

    lvdc_cmp_if cmp_link ();

    // Byte write replaces the image, bit write changes one bit of it
    function automatic logic [7:0] lvdc_merge(
        input logic [7:0] old_v,
        input logic       byte_wr,
        input logic       bit_wr,
        input logic [2:0] pos,
        input logic [7:0] wd
    );
        logic [7:0] v;
        v = old_v;
        if (byte_wr)
            v = wd;
        else if (bit_wr)
            v[pos] = wd[0];
        return v;
    endfunction

    // Qualifier sees the enable and the raw comparator level
    assign cmp_link.arm = st.enable;
    assign cmp_link.raw = comp_below_raw;

    lvdc_filter u_filter (
        .clock   (clock),
        .sys_rst (sys_rst),
        .ce      (ce),
        .cmp     (cmp_link)
    );

    // Register images as the bus sees them
    always_comb
    begin
        flag                = cmp_link.below;
        wr_any              = mem_wr | mem_bit_wr;
        ctl_img             = 8'h00;
        ctl_img[CTL_EN_BIT] = st.enable;
        ctl_img[SRC_BIT]    = st.src;
        ctl_img[MODE_BIT]   = st.mode;
        ctl_img[FLAG_BIT]   = flag & st.enable;
        lvl_img             = {{(8 - LVL_W){1'b0}}, st.lvl};
        dir_img             = {DIR_RST[7:DIR_W], st.dir};
        w_ctl = lvdc_merge(ctl_img, mem_wr, mem_bit_wr, mem_bit_pos,
                           mem_wdata);
        w_lvl = lvdc_merge(lvl_img, mem_wr, mem_bit_wr, mem_bit_pos,
                           mem_wdata);
        w_dir = lvdc_merge(dir_img, mem_wr, mem_bit_wr, mem_bit_pos,
                           mem_wdata);
    end

    // Next state: writes, event detection, reset request, read data
    always_comb
    begin
        next_st = st;
        // Flag bit is read-only, so a write to bit 0 is dropped
        if (wr_any && mem_addr == ADDR_CTL)
        begin
            next_st.enable = w_ctl[CTL_EN_BIT];
            next_st.src    = w_ctl[SRC_BIT];
            next_st.mode   = w_ctl[MODE_BIT];
        end
        // Upper level bits are not stored and read back as zero
        if (wr_any && mem_addr == ADDR_LVL)
            next_st.lvl = w_lvl[LVL_W-1:0];
        // The detector's own reset forces every pin to input
        if (st.rst_req)
            next_st.dir = DIR_RST[DIR_W-1:0];
        else if (wr_any && mem_addr == ADDR_DIR)
            next_st.dir = w_dir[DIR_W-1:0];
        // In interrupt mode any flag change interrupts, including the fall on disable
        next_st.prev_flag = flag;
        next_st.irq       = !st.mode && (flag != st.prev_flag);
        next_st.rst_req   = st.enable && st.mode && flag;
        next_st.cause     = next_st.rst_req && !st.rst_req;
        // Unmapped reads return zero
        if (mem_rd)
        begin
            unique case (mem_addr)
                ADDR_CTL: next_st.rdata = ctl_img;
                ADDR_LVL: next_st.rdata = lvl_img;
                ADDR_DIR: next_st.rdata = dir_img;
                default:  next_st.rdata = 8'h00;
            endcase
        end
    end

    // Config other than direction is untouched by our own reset; only sys_rst clears it
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            st <= ST_RST;
        else if (ce)
            st <= next_st;
    end

    // Analog controls; the fixed reference makes the code irrelevant
    assign comp_enable        = st.enable;
    assign use_fixed_ref      = st.src;
    assign threshold_level    = st.src ? '0 : st.lvl;
    assign low_voltage_irq    = st.irq;
    assign detector_reset_req = st.rst_req;
    assign reset_cause_set    = st.cause;
    // Mask comes back on for either kind of reset
    assign irq_mask_set       = sys_rst | st.rst_req;
    assign pin_oe             = ~st.dir;
    assign mem_rdata          = st.rdata;

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    dir_forced_a: assert property (
        ce && st.rst_req |=> st.dir == DIR_RST[DIR_W-1:0])
        else $error("direction not forced to input during own reset");
    dir_upper_a: assert property (
        ce && mem_rd && mem_addr == ADDR_DIR |=> mem_rdata[7:DIR_W] == '1)
        else $error("direction upper bits did not read as one");
    ctl_zero_a: assert property (
        ce && mem_rd && mem_addr == ADDR_CTL |=> mem_rdata[6:3] == 4'h0)
        else $error("control bits 6 to 3 not zero");
    flag_off_a: assert property (
        ce && !st.enable |=> !cmp_link.below)
        else $error("flag set while detection disabled");
    irq_edge_a: assert property (
        ce && !st.mode && (cmp_link.below != st.prev_flag)
        |=> low_voltage_irq)
        else $error("crossing in interrupt mode gave no interrupt");
    irq_quiet_a: assert property (
        ce && st.mode |=> !low_voltage_irq)
        else $error("interrupt raised in reset mode");
    rst_follow_a: assert property (
        ce && st.enable && st.mode && cmp_link.below
        |=> detector_reset_req)
        else $error("internal reset not held while below level");
    rst_release_a: assert property (
        ce && !cmp_link.below |=> !detector_reset_req)
        else $error("internal reset held at or above level");
    cause_pulse_a: assert property (
        $rose(detector_reset_req) |-> reset_cause_set)
        else $error("reset cause not set by detector reset");
    keep_cfg_a: assert property (
        ce && st.rst_req && !mem_wr && !mem_bit_wr
        |=> $stable(st.enable) && $stable(st.mode) && $stable(st.lvl))
        else $error("configuration changed by own reset");
    off_irq_a: assert property (
        ce && st.enable && !st.mode && cmp_link.below && mem_wr
        && mem_addr == ADDR_CTL && mem_wdata == 8'h00 ##1 ce [*2]
        |=> low_voltage_irq)
        else $error("disable while below gave no interrupt");
    lvl_write_a: assert property (
        ce && mem_wr && mem_addr == ADDR_LVL
        |=> st.lvl == $past(mem_wdata[LVL_W-1:0]))
        else $error("level byte write not stored");
    mask_set_a: assert property (
        detector_reset_req |-> irq_mask_set)
        else $error("mask not set during own reset");

    irq_seen_c: cover property (low_voltage_irq);
    rst_seen_c: cover property ($rose(detector_reset_req));
    rst_end_c: cover property ($fell(detector_reset_req));
    bit_wr_c: cover property (mem_bit_wr && mem_addr == ADDR_CTL);
endmodule

// ---- shared/lvdc_cmp_if.sv ----
// Link between the control registers and the comparator qualifier
interface lvdc_cmp_if;
    logic arm;
    logic raw;
    logic below;
    modport filt (input arm, input raw, output below);
    modport ctrl (output arm, output raw, input below);
endinterface

// ---- shared/lvdc_pkg.sv ----
// Constants shared by the low-voltage detector control block
package lvdc_pkg;
    // Register addresses on the internal bus
    localparam logic [15:0] ADDR_DIR    = 16'hff2c;
    localparam logic [15:0] ADDR_CTL    = 16'hffbe;
    localparam logic [15:0] ADDR_LVL    = 16'hffbf;
    // Control register field positions
    localparam int          CTL_EN_BIT  = 7;
    localparam int          SRC_BIT     = 2;
    localparam int          MODE_BIT    = 1;
    localparam int          FLAG_BIT    = 0;
    // Values after a non-detector reset
    localparam logic [7:0]  CTL_RST     = 8'h00;
    localparam logic [7:0]  LVL_RST     = 8'h00;
    localparam logic [7:0]  DIR_RST     = 8'hff;
    // Stored widths
    localparam int          LVL_W       = 4;
    localparam int          DIR_W       = 3;
    // Timing at a 20 MHz clock, least times rounded up
    localparam int          CLK_KHZ     = 20000;
    localparam int          STAB_US     = 10;
    localparam int          PERSIST_US  = 200;
    localparam int          STAB_CYC    = (STAB_US * CLK_KHZ + 999) / 1000;
    localparam int          PERSIST_CYC = (PERSIST_US * CLK_KHZ + 999) / 1000;
    localparam int          PERSIST_W   = 12;
endpackage

// ---- sim/tb_lvdc_top.sv ----
// Self-checking bench for the low-voltage detector control block
module tb_lvdc_top;
    timeunit 1ns;
    timeprecision 1ns;
    import lvdc_pkg::*;

    logic             clock;
    logic             sys_rst;
    logic             ce;
    logic [15:0]      mem_addr;
    logic             mem_rd;
    logic             mem_wr;
    logic             mem_bit_wr;
    logic [2:0]       mem_bit_pos;
    logic [7:0]       mem_wdata;
    logic [7:0]       mem_rdata;
    logic             comp_below_raw;
    logic             comp_enable;
    logic             use_fixed_ref;
    logic [LVL_W-1:0] threshold_level;
    logic             low_voltage_irq;
    logic             detector_reset_req;
    logic             reset_cause_set;
    logic             irq_mask_set;
    logic [DIR_W-1:0] pin_oe;
    int               failures;
    int               checks_done;
    int               irq_cnt;
    int               cause_cnt;
    int               n;
    int               c0;

    lvdc_top dut_u (
        .clock              (clock),
        .sys_rst            (sys_rst),
        .ce                 (ce),
        .mem_addr           (mem_addr),
        .mem_rd             (mem_rd),
        .mem_wr             (mem_wr),
        .mem_bit_wr         (mem_bit_wr),
        .mem_bit_pos        (mem_bit_pos),
        .mem_wdata          (mem_wdata),
        .mem_rdata          (mem_rdata),
        .comp_below_raw     (comp_below_raw),
        .comp_enable        (comp_enable),
        .use_fixed_ref      (use_fixed_ref),
        .threshold_level    (threshold_level),
        .low_voltage_irq    (low_voltage_irq),
        .detector_reset_req (detector_reset_req),
        .reset_cause_set    (reset_cause_set),
        .irq_mask_set       (irq_mask_set),
        .pin_oe             (pin_oe)
    );

    // 20 MHz system clock
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Pulse counters, sampled before the edge's own updates land
    always @(posedge clock)
    begin
        if (low_voltage_irq === 1'b1) irq_cnt++;
        if (reset_cause_set === 1'b1) cause_cnt++;
    end

    task automatic wrap_up();
        if (failures == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Case equality so an unknown never passes
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask

    // Byte write, one cycle strobe
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clock);
        mem_addr  = a;
        mem_wdata = d;
        mem_wr    = 1'b1;
        @(negedge clock);
        mem_wr    = 1'b0;
    endtask

    // Single-bit write, value taken from data bit 0
    task automatic bwr(input logic [15:0] a, input logic [2:0] p,
                       input logic v);
        @(negedge clock);
        mem_addr    = a;
        mem_bit_pos = p;
        mem_wdata   = {7'h00, v};
        mem_bit_wr  = 1'b1;
        @(negedge clock);
        mem_bit_wr  = 1'b0;
    endtask

    // Read; data is registered and settled by the next falling edge
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clock);
        mem_addr = a;
        mem_rd   = 1'b1;
        @(negedge clock);
        mem_rd   = 1'b0;
        chk({8'h00, mem_rdata}, {8'h00, e}, "read data");
    endtask

    // Bounded wait for the interrupt pulse or the reset request
    task automatic wait_for(input bit sel, input int lim, output int k);
        k = 0;
        while (k < lim && (sel ? detector_reset_req : low_voltage_irq)
               !== 1'b1)
        begin
            @(negedge clock);
            k++;
        end
        if (k >= lim)
        begin
            failures++;
            $display("wrong value at %0t: wait ran out", $time);
            wrap_up();
        end
    endtask

    initial
    begin
        {mem_rd, mem_wr, mem_bit_wr, comp_below_raw} = 4'h0;
        mem_addr = 16'h0000;
        mem_bit_pos = 3'h0;
        mem_wdata = 8'h00;
        ce = 1'b1;
        sys_rst = 1'b1;
        {failures, checks_done, irq_cnt, cause_cnt} = '0;
        repeat (12) @(negedge clock);
        chk({15'h0, irq_mask_set}, 16'h1, "mask during reset");
        sys_rst = 1'b0;
        // Reset values and read-only / unstored bits
        rd(ADDR_CTL, 8'h00);
        rd(ADDR_LVL, 8'h00);
        rd(ADDR_DIR, 8'hff);
        rd(16'h1234, 8'h00);
        chk({13'h0, pin_oe}, 16'h0, "buffers off");
        wr(ADDR_DIR, 8'h00);
        rd(ADDR_DIR, 8'hf8);
        chk({13'h0, pin_oe}, 16'h7, "buffers on");
        bwr(ADDR_DIR, 3'h1, 1'b1);
        rd(ADDR_DIR, 8'hfa);
        chk({13'h0, pin_oe}, 16'h5, "one buffer off");
        bwr(ADDR_DIR, 3'h0, 1'b1);
        chk({13'h0, pin_oe}, 16'h4, "sense pin input");
        wr(ADDR_LVL, 8'h0f);
        rd(ADDR_LVL, 8'h0f);
        // External sense: fixed reference, flag bit not writable
        wr(ADDR_CTL, 8'hfd);
        rd(ADDR_CTL, 8'h84);
        chk({14'h0, comp_enable, use_fixed_ref}, 16'h3, "src");
        chk({12'h0, threshold_level}, 16'h0, "level");
        wr(ADDR_CTL, 8'h00);
        chk({15'h0, comp_enable}, 16'h0, "off");
        // Interrupt mode on the supply
        wr(ADDR_CTL, 8'h80);
        chk({11'h0, use_fixed_ref, threshold_level}, 16'hf, "lvl");
        repeat (STAB_CYC) @(negedge clock);
        comp_below_raw = 1'b1;
        wait_for(1'b0, PERSIST_CYC + 20, n);
        chk(16'(n >= PERSIST_CYC), 16'h1, "persist time");
        rd(ADDR_CTL, 8'h81);
        comp_below_raw = 1'b0;
        wait_for(1'b0, 10, n);
        rd(ADDR_CTL, 8'h80);
        // Below-level pulse too short to count
        c0 = irq_cnt;
        comp_below_raw = 1'b1;
        repeat (3000) @(negedge clock);
        comp_below_raw = 1'b0;
        repeat (10) @(negedge clock);
        chk(16'(irq_cnt - c0), 16'h0, "short pulse");
        // Disable while below raises the interrupt
        comp_below_raw = 1'b1;
        wait_for(1'b0, PERSIST_CYC + 20, n);
        repeat (2) @(negedge clock);
        c0 = irq_cnt;
        bwr(ADDR_CTL, 3'h7, 1'b0);
        repeat (6) @(negedge clock);
        chk(16'(irq_cnt - c0), 16'h1, "disable irq");
        rd(ADDR_CTL, 8'h00);
        comp_below_raw = 1'b0;
        // Reset mode: own reset keeps control and level
        wr(ADDR_CTL, 8'h80);
        repeat (STAB_CYC) @(negedge clock);
        rd(ADDR_CTL, 8'h80);
        wr(ADDR_CTL, 8'h82);
        c0 = cause_cnt;
        comp_below_raw = 1'b1;
        wait_for(1'b1, PERSIST_CYC + 20, n);
        chk(16'(n >= PERSIST_CYC), 16'h1, "reset delay");
        chk({15'h0, irq_mask_set}, 16'h1, "mask on own reset");
        rd(ADDR_CTL, 8'h83);
        chk({13'h0, pin_oe}, 16'h0, "dir forced");
        rd(ADDR_LVL, 8'h0f);
        chk(16'(cause_cnt - c0), 16'h1, "cause pulse");
        comp_below_raw = 1'b0;
        repeat (5) @(negedge clock);
        chk({15'h0, detector_reset_req}, 16'h0, "release");
        // Other reset clears everything
        sys_rst = 1'b1;
        @(negedge clock);
        sys_rst = 1'b0;
        rd(ADDR_CTL, 8'h00);
        rd(ADDR_LVL, 8'h00);
        rd(ADDR_DIR, 8'hff);
        wrap_up();
    end
endmodule
